// *** hw/mbtm_mask_cmp.sv ***
`timescale 1ns/1ps
module mbtm_mask_cmp #(
  parameter int W = 24
) (
  input wire logic [W-1:0] i_value,
  input wire logic [W-1:0] i_bench,
  input wire logic [W-1:0] i_mask,
  output logic o_match
);

  // Zero mask bits drop out, so 2**zeros values match
  assign o_match = ~|((i_value ^ i_bench) & i_mask);

endmodule // mbtm_mask_cmp

// *** hw/mbtm_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Zero mask bits are ignored, ones must equal
// - Matching set holds two to zero-count values
// - Bench 001A mask FFF8 matches 0018-001F
// - Bench 001A mask FFFC matches 0018-001B
// - Power-up: 16-bit address, eight data probes
// - Extended count moves harness lines to address
// - Address plus data probe lines always eight
// - Extended bits sit above 16 address bits
// - One extended bit gives 17-bit address
// - Harness bit 0 is address MSB
// - Low 16 bits come from target connection
// - Extension affects breakpoint, trace and the o_cmp_addr and o_ext_data outputs
// - Count change clears all qualifier settings
module mbtm_top #(
  parameter int HARNESS_W = mbtm_pkg::HARNESS_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [mbtm_pkg::REG_ADDR_W-1:0] i_tgt_addr,
  input wire logic i_bus_valid,
  input wire logic [HARNESS_W-1:0] i_probe_connector,
  input wire logic i_session_setup,
  input wire logic [mbtm_pkg::EXT_CNT_W-1:0] i_ext_addr_count,
  input wire logic i_masked_breakpoint_cmd,
  input wire logic i_masked_trace_cmd,
  input wire logic [mbtm_pkg::FULL_ADDR_W-1:0] i_addr_bench,
  input wire logic [mbtm_pkg::FULL_ADDR_W-1:0] i_addr_mask,
  input wire logic [HARNESS_W-1:0] i_data_bench,
  input wire logic [HARNESS_W-1:0] i_data_mask,
  output logic o_bp_hit,
  output logic o_trace_qual,
  output logic o_bp_armed,
  output logic o_tr_armed,
  output logic [mbtm_pkg::EXT_CNT_W-1:0] o_ext_addr_count,
  output logic [mbtm_pkg::FULL_ADDR_W-1:0] o_cmp_addr,
  output logic [HARNESS_W-1:0] o_ext_data
);

  localparam int AW = mbtm_pkg::FULL_ADDR_W;
  localparam int RW = mbtm_pkg::REG_ADDR_W;
  localparam int CW = mbtm_pkg::EXT_CNT_W;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [AW-1:0] compose_addr(input logic [CW-1:0] cnt, input logic [RW-1:0] tgt,
                                                 input logic [HARNESS_W-1:0] h);
    logic [AW-1:0] a;
    a = {{(AW-RW){1'b0}}, tgt};
    for (int k = 0; k < HARNESS_W; k++) begin
      // Bit 0 lands highest, later lines fill downward
      if (k < int'(cnt)) begin
        a[RW + int'(cnt) - 1 - k] = h[k];
      end
    end
    return a;
  endfunction

  function automatic logic [HARNESS_W-1:0] split_data(input logic [CW-1:0] cnt, input logic [HARNESS_W-1:0] h);
    logic [HARNESS_W-1:0] d;
    d = '0;
    for (int j = 0; j < HARNESS_W; j++) begin
      if (j + int'(cnt) < HARNESS_W) begin
        d[j] = h[j + int'(cnt)];
      end
    end
    return d;
  endfunction

  function automatic logic [AW-1:0] addr_span(input logic [CW-1:0] cnt);
    logic [AW-1:0] m;
    m = '0;
    for (int b = 0; b < AW; b++) begin
      if (b < RW + int'(cnt)) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [HARNESS_W-1:0] data_span(input logic [CW-1:0] cnt);
    logic [HARNESS_W-1:0] m;
    m = '0;
    for (int b = 0; b < HARNESS_W; b++) begin
      if (b + int'(cnt) < HARNESS_W) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [RW-1:0] tgt_s1_reg;
  logic [RW-1:0] tgt_s2_reg;
  logic [HARNESS_W-1:0] probe_s1_reg;
  logic [HARNESS_W-1:0] probe_s2_reg;
  logic valid_s1_reg;
  logic valid_s2_reg;

  // Multi-bit values are sampled as a group; the target holds them with valid
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgt_s1_reg <= '0;
      tgt_s2_reg <= '0;
      probe_s1_reg <= '0;
      probe_s2_reg <= '0;
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
    end else begin
      tgt_s1_reg <= i_tgt_addr;
      tgt_s2_reg <= tgt_s1_reg;
      probe_s1_reg <= i_probe_connector;
      probe_s2_reg <= probe_s1_reg;
      valid_s1_reg <= i_bus_valid;
      valid_s2_reg <= valid_s1_reg;
    end
  end

  // ------------------------------------------------------------------
  // Session setup
  // ------------------------------------------------------------------
  logic [CW-1:0] ext_cnt_reg;
  logic [CW-1:0] ext_cnt_next;
  logic cnt_change;

  // Out-of-range requests saturate rather than wrap
  assign ext_cnt_next = (i_ext_addr_count > mbtm_pkg::EXT_CNT_MAX) ? mbtm_pkg::EXT_CNT_MAX
                                                                   : i_ext_addr_count;
  assign cnt_change = i_session_setup && (ext_cnt_next != ext_cnt_reg);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_cnt_reg <= mbtm_pkg::EXT_CNT_RST;
    end else if (i_session_setup) begin
      ext_cnt_reg <= ext_cnt_next;
    end
  end

  // ------------------------------------------------------------------
  // Qualifier settings, slot 0 breakpoint, slot 1 trace
  // ------------------------------------------------------------------
  logic [AW-1:0] addr_bench_reg [mbtm_pkg::QUAL_N];
  logic [AW-1:0] addr_mask_reg [mbtm_pkg::QUAL_N];
  logic [HARNESS_W-1:0] data_bench_reg [mbtm_pkg::QUAL_N];
  logic [HARNESS_W-1:0] data_mask_reg [mbtm_pkg::QUAL_N];
  logic [mbtm_pkg::QUAL_N-1:0] armed_reg;
  logic [mbtm_pkg::QUAL_N-1:0] load;

  assign load[mbtm_pkg::SLOT_BP] = i_masked_breakpoint_cmd;
  assign load[mbtm_pkg::SLOT_TR] = i_masked_trace_cmd;

  // A changed count wins over a load in the same cycle: old settings are stale
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed_reg <= '0;
      for (int q = 0; q < mbtm_pkg::QUAL_N; q++) begin
        addr_bench_reg[q] <= mbtm_pkg::ADDR_RST;
        addr_mask_reg[q] <= mbtm_pkg::ADDR_RST;
        data_bench_reg[q] <= mbtm_pkg::DATA_RST;
        data_mask_reg[q] <= mbtm_pkg::DATA_RST;
      end
    end else begin
      for (int q = 0; q < mbtm_pkg::QUAL_N; q++) begin
        if (cnt_change) begin
          armed_reg[q] <= 1'b0;
          addr_bench_reg[q] <= mbtm_pkg::ADDR_RST;
          addr_mask_reg[q] <= mbtm_pkg::ADDR_RST;
          data_bench_reg[q] <= mbtm_pkg::DATA_RST;
          data_mask_reg[q] <= mbtm_pkg::DATA_RST;
        end else if (load[q]) begin
          armed_reg[q] <= 1'b1;
          addr_bench_reg[q] <= i_addr_bench;
          addr_mask_reg[q] <= i_addr_mask;
          data_bench_reg[q] <= i_data_bench;
          data_mask_reg[q] <= i_data_mask;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Compare
  // ------------------------------------------------------------------
  logic [AW-1:0] obs_addr;
  logic [HARNESS_W-1:0] obs_data;
  logic [mbtm_pkg::QUAL_N-1:0] addr_hit;
  logic [mbtm_pkg::QUAL_N-1:0] data_hit;
  logic [mbtm_pkg::QUAL_N-1:0] hit_next;

  // The qualifier compare and the o_cmp_addr output both see the widened address
  assign obs_addr = compose_addr(ext_cnt_reg, tgt_s2_reg, probe_s2_reg);
  assign obs_data = split_data(ext_cnt_reg, probe_s2_reg);

  for (genvar g = 0; g < mbtm_pkg::QUAL_N; g++) begin : g_qual
    mbtm_mask_cmp #(.W(AW)) u_addr_cmp (
      .i_value(obs_addr),
      .i_bench(addr_bench_reg[g]),
      .i_mask(addr_mask_reg[g] & addr_span(ext_cnt_reg)),
      .o_match(addr_hit[g])
    );
    mbtm_mask_cmp #(.W(HARNESS_W)) u_data_cmp (
      .i_value(obs_data),
      .i_bench(data_bench_reg[g]),
      .i_mask(data_mask_reg[g] & data_span(ext_cnt_reg)),
      .o_match(data_hit[g])
    );
    assign hit_next[g] = armed_reg[g] && valid_s2_reg && addr_hit[g] && data_hit[g];
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  logic [mbtm_pkg::QUAL_N-1:0] hit_reg;
  logic [AW-1:0] cmp_addr_reg;
  logic [HARNESS_W-1:0] ext_data_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hit_reg <= '0;
      cmp_addr_reg <= mbtm_pkg::ADDR_RST;
      ext_data_reg <= mbtm_pkg::DATA_RST;
    end else begin
      hit_reg <= hit_next;
      cmp_addr_reg <= obs_addr;
      ext_data_reg <= obs_data;
    end
  end

  assign o_bp_hit = hit_reg[mbtm_pkg::SLOT_BP];
  assign o_trace_qual = hit_reg[mbtm_pkg::SLOT_TR];
  assign o_bp_armed = armed_reg[mbtm_pkg::SLOT_BP];
  assign o_tr_armed = armed_reg[mbtm_pkg::SLOT_TR];
  assign o_ext_addr_count = ext_cnt_reg;
  assign o_cmp_addr = cmp_addr_reg;
  assign o_ext_data = ext_data_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_fff8_armed;
    o_bp_armed && addr_bench_reg[mbtm_pkg::SLOT_BP] == mbtm_pkg::EX_BENCH &&
      addr_mask_reg[mbtm_pkg::SLOT_BP] == mbtm_pkg::EX_MASK_W8 && data_mask_reg[mbtm_pkg::SLOT_BP] == '0;
  endsequence

  sequence s_in_range;
    valid_s2_reg && obs_addr >= mbtm_pkg::EX_LO && obs_addr <= mbtm_pkg::EX_HI;
  endsequence

  a_fff8_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_fff8_armed and s_in_range |=> o_bp_hit)
    else $error("Value in masked range did not hit");

  a_hit_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_bp_hit |-> $past(valid_s2_reg && o_bp_armed) && ((o_cmp_addr ^ $past(addr_bench_reg[mbtm_pkg::SLOT_BP]))
      & $past(addr_mask_reg[mbtm_pkg::SLOT_BP] & addr_span(ext_cnt_reg))) == '0)
    else $error("Breakpoint hit without masked match");

  a_trace_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_trace_qual |-> $past(o_tr_armed) &&
      ((o_ext_data ^ $past(data_bench_reg[mbtm_pkg::SLOT_TR])) & $past(data_mask_reg[mbtm_pkg::SLOT_TR])
       & $past(data_span(ext_cnt_reg))) == '0)
    else $error("Trace qualified without data match");

  a_reset_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ~|{ext_cnt_reg, $past(ext_cnt_reg)} |-> o_cmp_addr[AW-1:RW] == '0 ##1 o_ext_data == $past(probe_s2_reg))
    else $error("Zero extension did not give sixteen bits and eight probes");

  a_one_bit_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ext_cnt_reg == mbtm_pkg::EXT_CNT_ONE && $stable(ext_cnt_reg) |=>
      o_cmp_addr[RW] == $past(probe_s2_reg[0]) && o_ext_data == {1'b0, $past(probe_s2_reg[HARNESS_W-1:1])} &&
      o_cmp_addr[AW-1:RW+1] == '0)
    else $error("One extended bit mapped wrongly");

  a_low_addr_path: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n, 2) |=> o_cmp_addr[RW-1:0] == $past(i_tgt_addr, 3))
    else $error("Low address not from target connection");

  a_count_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_session_setup |=> o_ext_addr_count <= mbtm_pkg::EXT_CNT_MAX &&
      (o_ext_addr_count == $past(i_ext_addr_count) || $past(i_ext_addr_count) > mbtm_pkg::EXT_CNT_MAX))
    else $error("Extended count out of range or not loaded");

  a_change_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cnt_change |=> !o_bp_armed && !o_tr_armed ##1 (!o_bp_hit && !o_trace_qual))
    else $error("Count change left a qualifier armed");

  a_probe_total: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $countones(addr_span(ext_cnt_reg)) - RW + $countones(data_span(ext_cnt_reg)) == HARNESS_W)
    else $error("Address and data probe lines do not total eight");

endmodule // mbtm_top

// *** include/mbtm_pkg.sv ***
package mbtm_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int REG_ADDR_W = 16;
  localparam int HARNESS_W = 8;
  localparam int FULL_ADDR_W = REG_ADDR_W + HARNESS_W;
  localparam int EXT_CNT_W = 4;
  localparam int QUAL_N = 2;

  // ------------------------------------------------------------------
  // Qualifier slots
  // ------------------------------------------------------------------
  localparam int SLOT_BP = 0;
  localparam int SLOT_TR = 1;

  // ------------------------------------------------------------------
  // Extended address count
  // ------------------------------------------------------------------
  localparam logic [EXT_CNT_W-1:0] EXT_CNT_RST = 4'h0;
  localparam logic [EXT_CNT_W-1:0] EXT_CNT_MAX = 4'h8;
  localparam logic [EXT_CNT_W-1:0] EXT_CNT_ONE = 4'h1;

  // ------------------------------------------------------------------
  // Reset values of qualifier settings
  // ------------------------------------------------------------------
  localparam logic [FULL_ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [HARNESS_W-1:0] DATA_RST = 8'h00;

  // ------------------------------------------------------------------
  // Worked mask example
  // ------------------------------------------------------------------
  localparam logic [FULL_ADDR_W-1:0] EX_BENCH = 24'h00001a;
  localparam logic [FULL_ADDR_W-1:0] EX_MASK_W8 = 24'h00fff8;
  localparam logic [FULL_ADDR_W-1:0] EX_LO = 24'h000018;
  localparam logic [FULL_ADDR_W-1:0] EX_HI = 24'h00001f;

endpackage

// *** tb/mbtm_target_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Target bus and user-wired probe lines
// ------------------------------------------------------------------
module mbtm_target_model (
  input wire logic i_clk,
  input wire logic [3:0] i_n,
  input wire logic i_drive,
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [15:0] o_tgt_addr,
  output logic o_bus_valid,
  output logic [7:0] o_probe_connector
);
  int n;
  initial begin
    o_tgt_addr = 16'h0000;
    o_bus_valid = 1'b0;
    o_probe_connector = 8'h00;
  end
  // Idle bus toggles every cycle so stale values never look valid
  always @(negedge i_clk) begin
    n = int'(i_n);
    o_bus_valid <= i_drive;
    if (i_drive) begin
      o_tgt_addr <= i_addr[15:0];
      for (int k = 0; k < 8; k++) begin
        if (k < n) begin
          o_probe_connector[k] <= i_addr[15 + n - k];
        end else begin
          o_probe_connector[k] <= i_data[k - n];
        end
      end
    end else begin
      o_tgt_addr <= ~o_tgt_addr;
      o_probe_connector <= ~o_probe_connector;
    end
  end
endmodule // mbtm_target_model

// *** tb/mbtm_top_tb_top.sv ***
`timescale 1ns/1ps
module mbtm_top_tb_top;
  logic i_clk, i_rst_n, i_session_setup, i_masked_breakpoint_cmd, i_masked_trace_cmd;
  logic [mbtm_pkg::EXT_CNT_W-1:0] i_ext_addr_count, o_ext_addr_count;
  logic [23:0] i_addr_bench, i_addr_mask, o_cmp_addr, req_addr, bp_b, bp_m, tr_b, tr_m;
  logic [7:0] i_data_bench, i_data_mask, o_ext_data, probe, req_data, bp_db, bp_dm, tr_db, tr_dm;
  logic [15:0] tgt_addr;
  logic bus_valid, drv, o_bp_hit, o_trace_qual, o_bp_armed, o_tr_armed, bp_arm, tr_arm;
  logic [3:0] cur_n;
  int mismatches, cmp_count, cycles, hits_bp, hits_tr;
  int unsigned seed_val;

  mbtm_target_model mbtm_target_model_i (.i_clk(i_clk), .i_n(cur_n), .i_drive(drv), .i_addr(req_addr),
    .i_data(req_data), .o_tgt_addr(tgt_addr), .o_bus_valid(bus_valid), .o_probe_connector(probe));
  mbtm_top mbtm_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tgt_addr(tgt_addr), .i_bus_valid(bus_valid),
    .i_probe_connector(probe), .i_session_setup(i_session_setup), .i_ext_addr_count(i_ext_addr_count),
    .i_masked_breakpoint_cmd(i_masked_breakpoint_cmd), .i_masked_trace_cmd(i_masked_trace_cmd),
    .i_addr_bench(i_addr_bench), .i_addr_mask(i_addr_mask), .i_data_bench(i_data_bench),
    .i_data_mask(i_data_mask), .o_bp_hit(o_bp_hit), .o_trace_qual(o_trace_qual), .o_bp_armed(o_bp_armed),
    .o_tr_armed(o_tr_armed), .o_ext_addr_count(o_ext_addr_count), .o_cmp_addr(o_cmp_addr),
    .o_ext_data(o_ext_data));

  // ------------------------------------------------------------------
  // Clock, timeout, checking
  // ------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      $display("ERROR cycles expected below %0d seen %0d", 8000, cycles);
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic exp_hit(input logic v, input logic arm, input logic [23:0] a, b, m,
                                   input logic [7:0] d, db, dm);
    logic [23:0] sp;
    logic [7:0] dsp;
    sp = (24'h1 << (16 + cur_n)) - 24'h1;
    dsp = (8'h1 << (8 - cur_n)) - 8'h1;
    return v && arm && (((a ^ b) & m & sp) == 24'h0) && (((d ^ db) & dm & dsp) == 8'h0);
  endfunction

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  // Loads together with a setup are only issued when the count changes
  task automatic setup(input logic [3:0] c, input logic with_load);
    logic [3:0] nn;
    @(negedge i_clk);
    i_session_setup <= 1'b1;
    i_ext_addr_count <= c;
    i_masked_breakpoint_cmd <= with_load;
    @(negedge i_clk);
    i_session_setup <= 1'b0;
    i_masked_breakpoint_cmd <= 1'b0;
    nn = (c > 4'h8) ? 4'h8 : c;
    if (nn != cur_n) begin
      bp_arm = 1'b0;
      tr_arm = 1'b0;
    end
    cur_n = nn;
    chk("ext_addr_count", 32'(nn), 32'(o_ext_addr_count));
    chk("bp_armed", 32'(bp_arm), 32'(o_bp_armed));
    chk("tr_armed", 32'(tr_arm), 32'(o_tr_armed));
  endtask
  task automatic load(input logic bp, input logic [23:0] b, m, input logic [7:0] db, dm);
    @(negedge i_clk);
    i_addr_bench <= b;
    i_addr_mask <= m;
    i_data_bench <= db;
    i_data_mask <= dm;
    i_masked_breakpoint_cmd <= bp;
    i_masked_trace_cmd <= !bp;
    @(negedge i_clk);
    i_masked_breakpoint_cmd <= 1'b0;
    i_masked_trace_cmd <= 1'b0;
    if (bp) {bp_arm, bp_b, bp_m, bp_db, bp_dm} = {1'b1, b, m, db, dm};
    else {tr_arm, tr_b, tr_m, tr_db, tr_dm} = {1'b1, b, m, db, dm};
    chk("bp_armed", 32'(bp_arm), 32'(o_bp_armed));
    chk("tr_armed", 32'(tr_arm), 32'(o_tr_armed));
  endtask
  task automatic sample(input logic v, input logic [23:0] a, input logic [7:0] d);
    logic eb, et;
    @(negedge i_clk);
    drv <= v;
    req_addr <= a;
    req_data <= d;
    repeat (5) @(negedge i_clk);
    eb = exp_hit(v, bp_arm, a, bp_b, bp_m, d, bp_db, bp_dm);
    et = exp_hit(v, tr_arm, a, tr_b, tr_m, d, tr_db, tr_dm);
    hits_bp += int'(eb);
    hits_tr += int'(et);
    if (v) begin
      chk("cmp_addr", 32'(a & ((24'h1 << (16 + cur_n)) - 24'h1)), 32'(o_cmp_addr));
      chk("ext_data", 32'(d & ((8'h1 << (8 - cur_n)) - 8'h1)), 32'(o_ext_data));
    end
    chk("bp_hit", 32'(eb), 32'(o_bp_hit));
    chk("trace_qual", 32'(et), 32'(o_trace_qual));
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {i_rst_n, i_session_setup, i_masked_breakpoint_cmd, i_masked_trace_cmd, drv, bp_arm, tr_arm} = '0;
    {i_ext_addr_count, cur_n, i_addr_bench, i_addr_mask, i_data_bench, i_data_mask} = '0;
    {req_addr, req_data, bp_b, bp_m, tr_b, tr_m, bp_db, bp_dm, tr_db, tr_dm} = '0;
    seed_val = $urandom(32'h1317907f);
    repeat (12) @(negedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk("ext_addr_count", 32'h0, 32'(o_ext_addr_count));
    sample(1'b1, 24'h00abcd, 8'ha5);
    load(1'b1, mbtm_pkg::EX_BENCH, mbtm_pkg::EX_MASK_W8, 8'h00, 8'h00);
    load(1'b0, mbtm_pkg::EX_BENCH, 24'h00fffc, 8'h00, 8'h00);
    hits_bp = 0;
    hits_tr = 0;
    for (int a = 16; a < 36; a++) sample(1'b1, 24'(a), 8'($urandom));
    chk("bp_set_size", 32'd8, 32'(hits_bp));
    chk("tr_set_size", 32'd4, 32'(hits_tr));
    sample(1'b0, mbtm_pkg::EX_BENCH, 8'h00);
    setup(4'h0, 1'b0);
    setup(4'h1, 1'b1);
    load(1'b1, 24'h01001a, 24'h01ffff, 8'h02, 8'h02);
    sample(1'b1, 24'h01001a, 8'h03);
    sample(1'b1, 24'h00001a, 8'h01);
    sample(1'b1, 24'h01001a, 8'h00);
    for (int c = 0; c <= 9; c++) begin
      setup(4'(c), 1'b0);
      load(1'b1, 24'($urandom), 24'($urandom), 8'($urandom), 8'($urandom));
      load(1'b0, 24'($urandom), 24'($urandom) | 24'h00fff0, 8'($urandom), 8'($urandom));
      sample(1'b1, bp_b, bp_db);
      sample(1'b1, tr_b ^ 24'h000003, tr_db);
      repeat (2) sample(1'b1, 24'($urandom), 8'($urandom));
    end
    setup(4'h2, 1'b0);
    load(1'b1, 24'h03ffff, 24'hffffff, 8'h00, 8'h00);
    sample(1'b1, 24'h03ffff, 8'($urandom));
    sample(1'b1, 24'h02ffff, 8'($urandom));
    end_of_test();
  end
endmodule // mbtm_top_tb_top
